// *** hdl/apf_pkg.sv ***
// constants and types shared by the amplifier protection and fault control block
package apf_pkg;
    // clock and derived timings (100 MHz core clock)
    localparam int CLK_HZ            = 100_000_000;
    localparam int SW_400K_HZ        = 400_000;
    localparam int SW_500K_HZ        = 500_000;
    localparam int SW_PER_400        = CLK_HZ / SW_400K_HZ;
    localparam int SW_PER_500        = CLK_HZ / SW_500K_HZ;
    localparam int SPREAD_SPAN       = 16;
    localparam int RETRY_MS          = 10;
    localparam int RETRY_CYC         = RETRY_MS * (CLK_HZ / 1000);
    localparam int DIAG_MS           = 260;
    localparam int DIAG_CYC          = DIAG_MS * (CLK_HZ / 1000);
    localparam int ATTACK_MS         = 55;
    localparam int RELEASE_MS        = 1500;
    localparam int GAIN_STEPS        = 32;
    localparam int ATTACK_STEP_CYC   = (ATTACK_MS * (CLK_HZ / 1000)) / GAIN_STEPS;
    localparam int RELEASE_STEP_CYC  = (RELEASE_MS * (CLK_HZ / 1000)) / GAIN_STEPS;
    localparam int THERM_STEP_MS     = 5;
    localparam int THERM_STEP_CYC    = THERM_STEP_MS * (CLK_HZ / 1000);
    // widths
    localparam int ATT_W             = 5;
    localparam int CNT_W             = 28;
    localparam int PER_W             = 9;
    // status bit positions
    localparam int ST_OC             = 0;
    localparam int ST_DC             = 1;
    localparam int ST_OT             = 2;
    localparam int ST_UV             = 3;
    localparam int ST_OV             = 4;
    localparam int ST_THW            = 5;
    localparam int ST_LSHORT         = 6;
    localparam int ST_LOPEN          = 7;
    localparam int ST_W              = 8;
    localparam logic [ST_W-1:0]  ST_RESET  = 8'h00;
    localparam logic [ATT_W-1:0] ATT_RESET = 5'h00;
    localparam logic [ATT_W-1:0] ATT_MAX   = 5'h1f;
    // operating modes, gray coded along shutdown->diag->play->fault
    typedef enum logic [1:0]
    {
        MODE_SHUTDOWN = 2'b00,
        MODE_DIAG     = 2'b01,
        MODE_PLAY     = 2'b11,
        MODE_FAULT    = 2'b10
    } apf_mode_e;
endpackage : apf_pkg

// *** hdl/apf_sync.sv ***
// three-flop synchroniser with agreement filter for one comparator flag
module apf_sync
    import apf_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // flag
    input  wire logic d_i,
    output logic      q_o
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic q_reg;
    wire  agree = (s2_reg == s3_reg);

    // change counts only once second and third stage agree
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            q_reg  <= 1'b0;
        end
        else
        begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (agree)
                q_reg <= s3_reg;
        end
    end
    assign q_o = q_reg;
endmodule : apf_sync

// *** hdl/apf_swgen.sv ***
// switching period generator: 400/500 khz with optional spread spectrum
module apf_swgen
    import apf_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // control
    input  wire logic run_i,
    input  wire logic freq_sel_i,
    input  wire logic spread_en_i,
    // period start pulse
    output logic      tick_o
);
    logic [PER_W-1:0] cnt_reg;
    logic [7:0]       lfsr_reg;
    logic             tick_reg;
    wire  [PER_W-1:0] base   = freq_sel_i ? PER_W'(SW_PER_500) : PER_W'(SW_PER_400);
    // dither of -8..+7 cycles around the centre period
    wire  [PER_W-1:0] dith   = PER_W'(lfsr_reg[3:0]) - PER_W'(SPREAD_SPAN / 2);
    wire  [PER_W-1:0] period = spread_en_i ? base + dith : base;
    wire              wrap   = (cnt_reg >= period - PER_W'(1));
    wire              fb     = lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3];

    // new dither value drawn once per switching period
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_reg  <= '0;
            lfsr_reg <= 8'h01;
            tick_reg <= 1'b0;
        end
        else if (!run_i)
        begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            cnt_reg  <= wrap ? '0 : cnt_reg + PER_W'(1);
            tick_reg <= wrap;
            if (wrap)
                lfsr_reg <= {lfsr_reg[6:0], fb};
        end
    end
    assign tick_o = tick_reg;
endmodule : apf_swgen

// *** hdl/apf_core.sv ***
// protection, fault reporting and operating-mode control for a mono class-d stage
module apf_core
    import apf_pkg::*;
#(
    parameter int RETRY_CYCLES   = RETRY_CYC,
    parameter int DIAG_CYCLES    = DIAG_CYC,
    parameter int ATTACK_CYCLES  = ATTACK_STEP_CYC,
    parameter int RELEASE_CYCLES = RELEASE_STEP_CYC,
    parameter int THERM_CYCLES   = THERM_STEP_CYC
)
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // pins
    input  wire logic             shutdown_in_n_i,
    output logic                  fault_out_n_o,
    output logic                  fault_out_n_oe_o,
    // analog comparator flags (asynchronous)
    input  wire logic             overcurrent_i,
    input  wire logic             dc_offset_i,
    input  wire logic             above_warning_i,
    input  wire logic             above_shutdown_i,
    input  wire logic             supply_low_i,
    input  wire logic             supply_high_i,
    input  wire logic             power_over_i,
    // load diagnostic result (same clock)
    input  wire logic             diag_open_i,
    input  wire logic             diag_short_i,
    // host control bits
    input  wire logic             freq_sel_i,
    input  wire logic             spread_en_i,
    input  wire logic             diag_disable_i,
    input  wire logic             status_clr_i,
    // power stage and status
    output logic                  bridge_hiz_o,
    output logic                  bridge_bias_o,
    output logic                  sw_tick_o,
    output logic                  osc_run_o,
    output logic                  i2c_run_o,
    output logic                  host_regs_rst_o,
    output logic [1:0]            mode_o,
    output logic [ATT_W-1:0]      thermal_att_o,
    output logic [ATT_W-1:0]      agc_att_o,
    output logic [ST_W-1:0]       status_o
);
    // synchronised flags
    localparam int NF = 8;
    logic [NF-1:0] raw;
    logic [NF-1:0] syn;
    // pin taken as-is: a freshly reset stage reads low, i.e. shut down, until the pin is seen high
    assign raw = {shutdown_in_n_i, power_over_i, supply_high_i, supply_low_i,
                  above_shutdown_i, above_warning_i, dc_offset_i, overcurrent_i};

    genvar gi;
    generate
        for (gi = 0; gi < NF; gi++)
        begin : g_sync
            apf_sync u_sync
            (
                .clk_i (clk_i),
                .rst_i (rst_i),
                .d_i   (raw[gi]),
                .q_o   (syn[gi])
            );
        end
    endgenerate

    wire oc_s   = syn[0];
    wire dc_s   = syn[1];
    wire thw_s  = syn[2];
    wire ots_s  = syn[3];
    wire uv_s   = syn[4];
    wire ov_s   = syn[5];
    wire pwr_s  = syn[6];
    wire sd_s   = !syn[7];

    // state
    apf_mode_e        mode_reg;
    apf_mode_e        mode_next;
    logic             oc_latch_reg;
    logic             dc_hold_reg;
    logic [CNT_W-1:0] retry_cnt_reg;
    logic [CNT_W-1:0] diag_cnt_reg;
    logic             ov_prev_reg;
    logic             ov_odd_reg;
    logic             diag_pend_reg;
    logic [ST_W-1:0]  status_reg;
    logic [ATT_W-1:0] th_att_reg;
    logic [ATT_W-1:0] agc_att_reg;
    logic [CNT_W-1:0] th_cnt_reg;
    logic [CNT_W-1:0] agc_cnt_reg;
    logic             fault_n_reg;
    logic             hiz_reg;
    logic             bias_reg;
    logic             osc_reg;
    logic             i2c_reg;
    logic             hreset_reg;
    logic             tick_w;

    // fault decode: any one of these forces hi-z
    wire retry_due = (retry_cnt_reg == CNT_W'(RETRY_CYCLES - 1));
    wire oc_active = oc_latch_reg;
    wire dc_fault  = dc_hold_reg;
    wire hard_flt  = oc_active || ots_s || uv_s || ov_s;
    wire any_flt   = hard_flt || dc_fault;
    wire diag_done = (diag_cnt_reg == CNT_W'(DIAG_CYCLES - 1));
    wire diag_bad  = diag_short_i; // open load alone does not block play
    wire ov_rise   = ov_s && !ov_prev_reg;

    // mode sequencing
    always_comb
    begin
        mode_next = mode_reg;
        unique case (mode_reg)
            MODE_SHUTDOWN:
                if (!sd_s)
                    mode_next = hard_flt ? MODE_FAULT : (diag_disable_i ? MODE_PLAY : MODE_DIAG);
            MODE_DIAG:
                if (hard_flt)
                    mode_next = MODE_FAULT; // faults abort diagnostics
                else if (diag_done && !diag_bad)
                    mode_next = MODE_PLAY;
            MODE_PLAY:
                if (any_flt)
                    mode_next = MODE_FAULT;
            MODE_FAULT:
                if (!any_flt)
                    mode_next = (diag_pend_reg && !diag_disable_i) ? MODE_DIAG : MODE_PLAY;
        endcase
        if (sd_s)
            mode_next = MODE_SHUTDOWN;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            mode_reg <= MODE_SHUTDOWN;
        else
            mode_reg <= mode_next;
    end

    // dc offset is only judged in play, but the fault must outlive the move to fault mode,
    // otherwise the hi-z bridge would hide the offset and the mode would bounce
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            dc_hold_reg <= 1'b0;
        else if (!dc_s || mode_reg == MODE_SHUTDOWN)
            dc_hold_reg <= 1'b0; // self-clearing
        else if (mode_reg == MODE_PLAY)
            dc_hold_reg <= 1'b1;
    end

    // overcurrent latch with periodic retry window
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            oc_latch_reg  <= 1'b0;
            retry_cnt_reg <= '0;
        end
        else if (oc_s && !oc_latch_reg)
        begin
            oc_latch_reg  <= 1'b1;
            retry_cnt_reg <= '0;
        end
        else if (oc_latch_reg)
        begin
            retry_cnt_reg <= retry_due ? '0 : retry_cnt_reg + CNT_W'(1);
            if (retry_due && !oc_s)
                oc_latch_reg <= 1'b0; // retry only if the cause has gone
        end
    end

    // diagnostic timer repeats while a short is present
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            diag_cnt_reg <= '0;
        else if (mode_reg != MODE_DIAG || diag_done)
            diag_cnt_reg <= '0; // a bad load restarts the check
        else
            diag_cnt_reg <= diag_cnt_reg + CNT_W'(1);
    end

    // diagnostics owed after a fault; overvoltage only on every second event
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ov_prev_reg   <= 1'b0;
            ov_odd_reg    <= 1'b0;
            diag_pend_reg <= 1'b0;
        end
        else
        begin
            ov_prev_reg <= ov_s;
            if (ov_rise)
                ov_odd_reg <= !ov_odd_reg;
            if (mode_reg == MODE_DIAG)
                diag_pend_reg <= 1'b0;
            if (ov_rise && ov_odd_reg)
                diag_pend_reg <= 1'b1;
            else if (oc_active || ots_s || uv_s || dc_fault)
                diag_pend_reg <= 1'b1;
        end
    end

    // status: sticky causes, set wins over host clear; dc tracks live
    // undervoltage empties the host view, so only the uv bit survives it
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            status_reg <= ST_RESET;
        else if (uv_s)
        begin
            status_reg         <= ST_RESET;
            status_reg[ST_UV]  <= 1'b1;
        end
        else
        begin
            if (status_clr_i)
                status_reg <= ST_RESET;
            if (oc_s)
                status_reg[ST_OC] <= 1'b1;
            status_reg[ST_DC] <= dc_fault; // self-clearing
            if (ots_s)
                status_reg[ST_OT] <= 1'b1;
            if (ov_s)
                status_reg[ST_OV] <= 1'b1;
            status_reg[ST_THW] <= thw_s;
            if (mode_reg == MODE_DIAG && diag_done)
            begin
                status_reg[ST_LSHORT] <= diag_short_i;
                status_reg[ST_LOPEN]  <= diag_open_i;
            end
        end
    end

    // thermal foldback steps gain down above warning, back up below
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            th_att_reg <= ATT_RESET;
            th_cnt_reg <= '0;
        end
        else if (th_cnt_reg == CNT_W'(THERM_CYCLES - 1))
        begin
            th_cnt_reg <= '0;
            if (thw_s && th_att_reg != ATT_MAX)
                th_att_reg <= th_att_reg + ATT_W'(1);
            else if (!thw_s && th_att_reg != ATT_RESET)
                th_att_reg <= th_att_reg - ATT_W'(1);
        end
        else
            th_cnt_reg <= th_cnt_reg + CNT_W'(1);
    end

    // limiter: fast attack, slow release; trades attack speed for click-free steps
    wire agc_due = pwr_s ? (agc_cnt_reg >= CNT_W'(ATTACK_CYCLES - 1))
                         : (agc_cnt_reg >= CNT_W'(RELEASE_CYCLES - 1));
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            agc_att_reg <= ATT_RESET;
            agc_cnt_reg <= '0;
        end
        else if (mode_reg != MODE_PLAY)
            agc_cnt_reg <= '0;
        else if (agc_due)
        begin
            agc_cnt_reg <= '0;
            if (pwr_s && agc_att_reg != ATT_MAX)
                agc_att_reg <= agc_att_reg + ATT_W'(1);
            else if (!pwr_s && agc_att_reg != ATT_RESET)
                agc_att_reg <= agc_att_reg - ATT_W'(1);
        end
        else
            agc_cnt_reg <= agc_cnt_reg + CNT_W'(1);
    end

    apf_swgen u_swgen
    (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .run_i       (mode_next == MODE_PLAY),
        .freq_sel_i  (freq_sel_i),
        .spread_en_i (spread_en_i),
        .tick_o      (tick_w)
    );

    // registered pin and stage outputs follow the next mode, so they change with mode_o
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fault_n_reg <= 1'b1;
            hiz_reg     <= 1'b1;
            bias_reg    <= 1'b0;
            osc_reg     <= 1'b0;
            i2c_reg     <= 1'b0;
            hreset_reg  <= 1'b1;
        end
        else
        begin
            fault_n_reg <= !(any_flt && mode_next != MODE_SHUTDOWN);
            hiz_reg     <= (mode_next != MODE_PLAY) || any_flt;
            bias_reg    <= (mode_next == MODE_DIAG);
            osc_reg     <= (mode_next != MODE_SHUTDOWN);
            i2c_reg     <= (mode_next != MODE_SHUTDOWN);
            hreset_reg  <= uv_s || (mode_next == MODE_SHUTDOWN);
        end
    end

    assign fault_out_n_o    = 1'b0; // open drain: only ever pulls low
    assign fault_out_n_oe_o = !fault_n_reg;
    assign bridge_hiz_o     = hiz_reg;
    assign bridge_bias_o    = bias_reg;
    assign sw_tick_o        = tick_w;
    assign osc_run_o        = osc_reg;
    assign i2c_run_o        = i2c_reg;
    assign host_regs_rst_o  = hreset_reg;
    assign mode_o           = mode_reg;
    assign thermal_att_o    = th_att_reg;
    assign agc_att_o        = agc_att_reg;
    assign status_o         = status_reg;
endmodule : apf_core

// *** tb/apf_monitor.sv ***
// port-level checker for the protection and fault control block
module apf_monitor
    import apf_pkg::*;
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // pin and bridge
    input  wire logic             fault_out_n_o,
    input  wire logic             fault_out_n_oe_o,
    input  wire logic             bridge_hiz_o,
    input  wire logic             bridge_bias_o,
    input  wire logic             sw_tick_o,
    // mode and status
    input  wire logic             osc_run_o,
    input  wire logic             i2c_run_o,
    input  wire logic             host_regs_rst_o,
    input  wire logic [1:0]       mode_o,
    input  wire logic [ATT_W-1:0] agc_att_o,
    input  wire logic [ST_W-1:0]  status_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // play decode, shared by several checks
    wire play_w = (mode_o == MODE_PLAY);

    a_shut_stops: assert property (mode_o == MODE_SHUTDOWN |->
        !osc_run_o && !i2c_run_o && bridge_hiz_o && !fault_out_n_oe_o) else $error("shutdown left a part running");
    a_modes_alive: assert property (mode_o != MODE_SHUTDOWN |-> osc_run_o && i2c_run_o)
        else $error("oscillator or i2c stopped outside shutdown");
    a_fault_hiz: assert property (mode_o == MODE_FAULT |-> bridge_hiz_o && !bridge_bias_o)
        else $error("fault mode bridge not hi-z");
    a_play_drives: assert property (play_w |-> !bridge_hiz_o && !bridge_bias_o)
        else $error("play mode bridge not switching");
    a_tick_play: assert property (sw_tick_o |-> play_w) else $error("switching tick outside play");
    a_pin_data: assert property (fault_out_n_o == 1'b0) else $error("fault pin data not low");
    a_oc_fault: assert property ($rose(status_o[ST_OC]) |-> ##[0:2] (fault_out_n_oe_o && bridge_hiz_o))
        else $error("overcurrent without fault and hi-z");
    a_ov_fault: assert property ($rose(status_o[ST_OV]) |-> ##[0:2] (fault_out_n_oe_o && bridge_hiz_o))
        else $error("overvoltage without fault and hi-z");
    a_uv_fault: assert property ($rose(status_o[ST_UV]) |-> ##[0:2] (fault_out_n_oe_o && host_regs_rst_o))
        else $error("undervoltage without fault and register reset");
    a_agc_steps: assert property (play_w && $past(play_w) && $changed(agc_att_o) |->
        agc_att_o == $past(agc_att_o) + 5'h01 || agc_att_o == $past(agc_att_o) - 5'h01) else $error("limiter jumped");
endmodule : apf_monitor

bind apf_core apf_monitor u_mon (.clk_i, .rst_i, .fault_out_n_o, .fault_out_n_oe_o, .bridge_hiz_o, .bridge_bias_o,
    .sw_tick_o, .osc_run_o, .i2c_run_o, .host_regs_rst_o, .mode_o, .agc_att_o, .status_o);

// *** tb/apf_host_model.sv ***
// far-side model: host driving the shutdown pin, pull-up on the fault line
module apf_host_model
(
    // clock
    input  wire logic clk_i,
    // request from the bench
    input  wire logic sd_req_i,
    // pins
    input  wire logic fault_out_n_i,
    input  wire logic fault_oe_i,
    output logic      shutdown_in_n_o,
    output logic      fault_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // the shutdown pin has no pull, so the host always drives it
    initial shutdown_in_n_o = 1'b0;
    always @(negedge clk_i) shutdown_in_n_o <= !sd_req_i;
    // open drain with pull-up: a released line reads high
    assign fault_pin_o = fault_oe_i ? fault_out_n_i : 1'b1;
endmodule : apf_host_model

// *** tb/tb_top.sv ***
// self-checking bench for the protection and fault control block
module tb_top
    import apf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // short counts so the whole run stays brief
    localparam int RT = 20;
    localparam int DG = 50;
    localparam int AT = 4;
    localparam int RL = 16;
    localparam int TH = 8;
    localparam int SB[4] = '{ST_OC, ST_OT, ST_UV, ST_OV};
    logic clk_i = 1'b0, rst_i = 1'b1, sd_req = 1'b0, fault_out_n_o, fault_out_n_oe_o, pin, shutdown_in_n_i;
    logic overcurrent_i = 1'b0, dc_offset_i = 1'b0, above_warning_i = 1'b0, above_shutdown_i = 1'b0;
    logic supply_low_i = 1'b0, supply_high_i = 1'b0, power_over_i = 1'b0, diag_open_i = 1'b0;
    logic diag_short_i = 1'b0, freq_sel_i = 1'b0, spread_en_i = 1'b0, status_clr_i = 1'b0, diag_disable_i = 1'b0;
    logic bridge_hiz_o, bridge_bias_o, sw_tick_o, osc_run_o, i2c_run_o, host_regs_rst_o;
    logic [1:0]       mode_o;
    logic [ATT_W-1:0] thermal_att_o, agc_att_o;
    logic [ST_W-1:0]  status_o;
    int num_errors = 0, n_compared = 0, cyc = 0, g, gp;

    apf_core #(.RETRY_CYCLES(RT), .DIAG_CYCLES(DG), .ATTACK_CYCLES(AT), .RELEASE_CYCLES(RL), .THERM_CYCLES(TH)) dut
        (.clk_i, .rst_i, .shutdown_in_n_i, .fault_out_n_o, .fault_out_n_oe_o, .overcurrent_i, .dc_offset_i,
        .above_warning_i, .above_shutdown_i, .supply_low_i, .supply_high_i, .power_over_i, .diag_open_i,
        .diag_short_i, .freq_sel_i, .spread_en_i, .diag_disable_i, .status_clr_i, .bridge_hiz_o,
        .bridge_bias_o, .sw_tick_o, .osc_run_o, .i2c_run_o, .host_regs_rst_o, .mode_o, .thermal_att_o,
        .agc_att_o, .status_o);
    apf_host_model host (.clk_i, .sd_req_i(sd_req), .fault_out_n_i(fault_out_n_o), .fault_oe_i(fault_out_n_oe_o),
        .shutdown_in_n_o(shutdown_in_n_i), .fault_pin_o(pin));

    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1)
        begin
            num_errors++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(negedge clk_i);
    endtask : idle
    // bounded wait on the mode, then judged
    task automatic wait_mode(input logic [1:0] m, input int lim, input string msg);
        int n;
        n = 0;
        while (mode_o !== m && n < lim)
        begin
            @(negedge clk_i);
            n++;
        end
        chk(mode_o === m, msg);
    endtask : wait_mode
    task automatic wait_left_fault();
        int n;
        n = 0;
        while (mode_o === MODE_FAULT && n < 3 * RT)
        begin
            @(negedge clk_i);
            n++;
        end
    endtask : wait_left_fault
    // cycles between two switching ticks
    task automatic tick_gap(output int gap);
        int n;
        n = 0;
        while (sw_tick_o !== 1'b1 && n < 1000)
        begin
            @(negedge clk_i);
            n++;
        end
        gap = 0;
        do
        begin
            @(negedge clk_i);
            gap++;
        end
        while (sw_tick_o !== 1'b1 && gap < 1000);
    endtask : tick_gap
    task automatic t_start();
        wait_mode(MODE_DIAG, 20, "start diag");
        wait_mode(MODE_PLAY, DG + 40, "start play");
        chk(osc_run_o && i2c_run_o && !bridge_hiz_o && pin === 1'b1, "play state");
        sd_req = 1'b1;
        wait_mode(MODE_SHUTDOWN, 10, "shutdown");
        chk(!osc_run_o && !i2c_run_o && bridge_hiz_o && pin === 1'b1, "shutdown state");
        sd_req = 1'b0;
        wait_mode(MODE_PLAY, DG + 40, "after shutdown");
        $display("test start_shutdown done");
    endtask : t_start
    // one hi-z fault: 0 overcurrent, 1 overtemp, 2 undervoltage, 3 overvoltage
    task automatic t_fault(input int k);
        {supply_high_i, supply_low_i, above_shutdown_i, overcurrent_i} = 4'(1 << k);
        idle(8);
        chk(fault_out_n_oe_o && bridge_hiz_o && pin === 1'b0, "fault raised");
        chk(status_o[SB[k]] === 1'b1, "cause bit");
        if (k == 2)
            chk(host_regs_rst_o === 1'b1, "registers reset");
        idle(3 * RT);
        chk(mode_o === MODE_FAULT && fault_out_n_oe_o === 1'b1, "fault held");
        {supply_high_i, supply_low_i, above_shutdown_i, overcurrent_i} = 4'h0;
        wait_mode(MODE_PLAY, 2 * RT + DG + 40, "recovered");
        chk(pin === 1'b1, "pin released");
        status_clr_i = 1'b1;
        idle(1);
        status_clr_i = 1'b0;
        idle(1);
        chk(status_o[SB[k]] === 1'b0, "cause cleared");
        $display("test fault %0d done", k);
    endtask : t_fault
    // second overvoltage runs diagnostics, third skips them; then overlap
    task automatic t_ov_overlap();
        for (int i = 0; i < 2; i++)
        begin
            supply_high_i = 1'b1;
            idle(8);
            supply_high_i = 1'b0;
            wait_left_fault();
            chk(mode_o === (i ? MODE_PLAY : MODE_DIAG), "diag after overvoltage");
            wait_mode(MODE_PLAY, DG + 40, "play after overvoltage");
        end
        above_shutdown_i = 1'b1;
        supply_high_i = 1'b1;
        idle(8);
        supply_high_i = 1'b0;
        idle(2 * RT);
        chk(fault_out_n_oe_o === 1'b1 && mode_o === MODE_FAULT, "one fault left");
        above_shutdown_i = 1'b0;
        wait_mode(MODE_PLAY, 2 * RT + DG + 40, "all clear");
        $display("test ov_overlap done");
    endtask : t_ov_overlap
    task automatic t_dc();
        dc_offset_i = 1'b1;
        idle(8);
        chk(fault_out_n_oe_o && status_o[ST_DC] === 1'b1 && pin === 1'b0, "dc fault");
        dc_offset_i = 1'b0;
        wait_mode(MODE_PLAY, 2 * RT + DG + 40, "dc recovered");
        chk(status_o[ST_DC] === 1'b0 && pin === 1'b1, "dc self clear");
        $display("test dc done");
    endtask : t_dc
    // thermal foldback and limiter both step, never jump
    task automatic t_gain();
        above_warning_i = 1'b1;
        idle(5 + TH * 4);
        chk(thermal_att_o > 0 && thermal_att_o < ATT_MAX && status_o[ST_THW] === 1'b1, "foldback steps");
        idle(TH * 40);
        chk(thermal_att_o === ATT_MAX, "foldback full");
        above_warning_i = 1'b0;
        idle(TH * 40);
        chk(thermal_att_o === ATT_RESET && status_o[ST_THW] === 1'b0, "foldback released");
        power_over_i = 1'b1;
        idle(5 + AT * 4);
        chk(agc_att_o > 0 && agc_att_o < ATT_MAX, "attack steps");
        idle(AT * 40);
        chk(agc_att_o === ATT_MAX, "attack full");
        power_over_i = 1'b0;
        idle(RL * 4);
        chk(agc_att_o > 0 && agc_att_o < ATT_MAX, "release slow");
        idle(RL * 40);
        chk(agc_att_o === ATT_RESET, "release done");
        $display("test gain done");
    endtask : t_gain
    task automatic t_freq();
        int nv;
        nv = 0;
        for (int s = 0; s < 2; s++)
        begin
            freq_sel_i = s[0];
            idle(600);
            tick_gap(g);
            chk(g === (s ? SW_PER_500 : SW_PER_400), "switching period");
        end
        freq_sel_i = 1'b0;
        spread_en_i = 1'b1;
        idle(600);
        tick_gap(gp);
        for (int i = 0; i < 4; i++)
        begin
            tick_gap(g);
            chk(g >= SW_PER_400 - 8 && g <= SW_PER_400 + 7, "spread range");
            nv += (g != gp);
            gp = g;
        end
        spread_en_i = 1'b0;
        chk(nv > 0, "spread varied");
        $display("test freq done");
    endtask : t_freq
    // shorted load holds hi-z and repeats; open load plays on
    task automatic t_diag();
        diag_short_i = 1'b1;
        rst_i = 1'b1;
        idle(2);
        rst_i = 1'b0;
        wait_mode(MODE_DIAG, 20, "diag run");
        idle(DG + 10);
        chk(status_o[ST_LSHORT] === 1'b1 && mode_o !== MODE_PLAY && bridge_hiz_o, "short held");
        diag_short_i = 1'b0;
        wait_mode(MODE_PLAY, 2 * DG + 40, "short removed");
        diag_open_i = 1'b1;
        rst_i = 1'b1;
        idle(2);
        rst_i = 1'b0;
        wait_mode(MODE_PLAY, DG + 40, "open plays");
        chk(status_o[ST_LOPEN] === 1'b1 && bridge_hiz_o === 1'b0, "open reported");
        diag_open_i = 1'b0;
        diag_disable_i = 1'b1;
        rst_i = 1'b1;
        idle(2);
        rst_i = 1'b0;
        idle(1);
        chk(mode_o === MODE_SHUTDOWN, "shut down until pin synced");
        wait_mode(MODE_PLAY, 12, "diag skipped");
        diag_disable_i = 1'b0;
        $display("test diag done");
    endtask : t_diag
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    // free-running clock
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end
    // hang guard, well above the expected run length
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            num_errors++;
            final_report();
        end
    end
    initial
    begin
        idle(5);
        rst_i = 1'b0;
        t_start();
        for (int k = 0; k < 4; k++)
            t_fault(k);
        t_ov_overlap();
        t_dc();
        t_gain();
        t_freq();
        t_diag();
        final_report();
    end
endmodule : tb_top
